// ### rtl/rpm_consts.vh
`ifndef RPM_CONSTS_VH
`define RPM_CONSTS_VH

// Timing
`define RPM_CLK_NS 40
`define RPM_OSC_PER_MC 12
`define RPM_STATE_LAST 3'h5
`define RPM_RST_HOLD_MC 2
`define RPM_RST_HOLD_CYC (`RPM_RST_HOLD_MC * `RPM_OSC_PER_MC)
`define RPM_WDT_PULSE_MC 3
`define RPM_WDT_PULSE_CYC (`RPM_WDT_PULSE_MC * `RPM_OSC_PER_MC)
`define RPM_SOFT_RESET_BIT_MC 2
`define RPM_SOFT_RESET_BIT_CYC (`RPM_SOFT_RESET_BIT_MC * `RPM_OSC_PER_MC)

// Register indices and byte addresses
`define RPM_IDX_PWR 8'h87
`define RPM_IDX_AUX 8'h8e
`define RPM_IDX_AUX1 8'ha2
`define RPM_IDX_STAT 8'hc0
`define RPM_A_PWR {2'h0, `RPM_IDX_PWR, 2'h0}
`define RPM_A_AUX {2'h0, `RPM_IDX_AUX, 2'h0}
`define RPM_A_AUX1 {2'h0, `RPM_IDX_AUX1, 2'h0}
`define RPM_A_STAT {2'h0, `RPM_IDX_STAT, 2'h0}

// Field positions
`define RPM_PWR_POF 5
`define RPM_PWR_WLE 4
`define RPM_PWR_PD 1
`define RPM_PWR_IDL 0
`define RPM_AUX_AO 0
`define RPM_AUX1_WAKE_ENABLE_BIT 3
`define RPM_AUX1_SOFT_RESET_BIT 5
`define RPM_ST_IDLE 0
`define RPM_ST_PD 1
`define RPM_ST_WAKE 2
`define RPM_ST_EMU 3
`define RPM_ST_RST 4
`define RPM_ST_OSC 5
`define RPM_ST_RAMBLK 6

// Reset values and responses
`define RPM_AUX_RST 3'h2
`define RPM_RESP_OKAY 2'h0
`define RPM_RESP_SLVERR 2'h2

`endif

// ### rtl/rpm_sync3.v
`timescale 1ns/1ns
module rpm_sync3 #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Asynchronous in, filtered level out
   input wire [W-1:0] async_in,
   output reg [W-1:0] level_reg
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_reg <= RST;
         s2_reg <= RST;
         s3_reg <= RST;
         level_reg <= RST;
      end
      else
      begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= (s2_reg & agree) | (level_reg & ~agree);
      end
   end
endmodule

// ### rtl/rpm_pulse_timer.v
`timescale 1ns/1ns
module rpm_pulse_timer #(
   parameter LEN = 36,
   parameter CW = 6
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Trigger and pulse
   input wire start,
   output reg active_reg
);
   reg [CW-1:0] cnt_reg;

   // Pulse lasts exactly LEN clocks; retrigger while active is ignored
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg <= {CW{1'b0}};
         active_reg <= 1'b0;
      end
      else if (!active_reg)
      begin
         if (start)
         begin
            active_reg <= 1'b1;
            cnt_reg <= LEN[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
         end
      end
      else if (cnt_reg == {CW{1'b0}})
         active_reg <= 1'b0;
      else
         cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
   end
endmodule

// ### rtl/rpm_power_ctrl.v
`timescale 1ns/1ns
`include "rpm_consts.vh"
module rpm_power_ctrl (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Reset pin
   input wire rst_pin,
   output reg rst_pullup_reg,
   // External interrupt pins, active low
   input wire ext_irq_zero_n,
   input wire ext_irq_one_n,
   // Strobe pins and other pin controls
   input wire ale_i,
   output reg ale_o_reg,
   output reg ale_oe_reg,
   input wire progstore_strobe_n_i,
   output reg progstore_strobe_n_o_reg,
   output reg progstore_strobe_n_oe_reg,
   output reg port0_float_reg,
   output reg pins_weak_pull_reg,
   output reg pwm_force_high_reg,
   // Watchdog
   input wire wdt_overflow,
   input wire wdt_enable,
   input wire wdt_loaded,
   output reg wdt_load_allow_reg,
   // Core side
   input wire core_instr_done,
   input wire irq_pending,
   input wire irq_en_zero,
   input wire irq_en_one,
   input wire irq_level_zero,
   input wire irq_level_one,
   input wire powerdown_allow_input,
   input wire core_ale,
   input wire core_progstore_strobe_n_n,
   input wire ext_prog_mem,
   input wire ext_mem_access,
   input wire power_on_detect,
   output reg int_clk_reg,
   output reg cpu_halt_reg,
   output reg periph_halt_reg,
   output reg osc_enable_reg,
   output reg core_reset_reg,
   output reg ram_block_reg
);
   localparam [3:0] M_RUN = 4'h1;
   localparam [3:0] M_IDLE = 4'h2;
   localparam [3:0] M_PD = 4'h4;
   localparam [3:0] M_WAKE = 4'h8;

   // Synchronised pins
   wire rst_lvl;
   wire irq0_n_lvl;
   wire irq1_n_lvl;
   wire ale_lvl;
   wire progstore_strobe_n_lvl;
   rpm_sync3 #(.W(5), .RST(5'h1e)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({rst_pin, ext_irq_zero_n, ext_irq_one_n, ale_i, progstore_strobe_n_i}),
      .level_reg({rst_lvl, irq0_n_lvl, irq1_n_lvl, ale_lvl, progstore_strobe_n_lvl})
   );

   // Divide by two; holds while the oscillator is stopped
   always @(posedge aclk)
   begin
      if (!aresetn)
         int_clk_reg <= 1'b0;
      else if (osc_enable_reg)
         int_clk_reg <= ~int_clk_reg;
   end

   // Reset sources
   localparam integer HOLD_INT = `RPM_RST_HOLD_CYC;
   localparam [4:0] HOLD_CYC = HOLD_INT[4:0];
   reg [4:0] rst_cnt_reg;
   wire hw_rst = rst_lvl && (rst_cnt_reg == HOLD_CYC);
   wire wdt_act;
   wire soft_reset_bit_act;
   reg soft_reset_bit_start;
   rpm_pulse_timer #(.LEN(`RPM_WDT_PULSE_CYC), .CW(6)) u_wdt_pulse (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(wdt_overflow & wdt_enable),
      .active_reg(wdt_act)
   );
   rpm_pulse_timer #(.LEN(`RPM_SOFT_RESET_BIT_CYC), .CW(6)) u_soft_reset_bit_pulse (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(soft_reset_bit_start),
      .active_reg(soft_reset_bit_act)
   );
   wire int_rst = hw_rst | wdt_act | soft_reset_bit_act;

   always @(posedge aclk)
   begin
      if (!aresetn)
         rst_cnt_reg <= 5'h0;
      else if (!rst_lvl)
         rst_cnt_reg <= 5'h0;
      else if (rst_cnt_reg != HOLD_CYC)
         rst_cnt_reg <= rst_cnt_reg + 5'h1;
   end

   // Register state
   reg pof_reg;
   reg wle_reg;
   reg pd_reg;
   reg idl_reg;
   reg [2:0] aux_reg;
   reg wake_enable_bit_reg;
   reg emu_reg;
   reg emu_cand_reg;
   reg [3:0] mode_reg;
   reg [3:0] mode_next;

   // AXI write path
   reg aw_got_reg;
   reg w_got_reg;
   reg [11:0] awaddr_reg;
   reg [7:0] wdata_reg;
   reg wlane_reg;
   wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   wire wr_en = do_write & wlane_reg;
   wire wr_pwr = wr_en && (awaddr_reg == `RPM_A_PWR);
   wire wr_aux = wr_en && (awaddr_reg == `RPM_A_AUX);
   wire wr_aux1 = wr_en && (awaddr_reg == `RPM_A_AUX1);
   wire wr_hit = (awaddr_reg == `RPM_A_PWR) || (awaddr_reg == `RPM_A_AUX)
      || (awaddr_reg == `RPM_A_AUX1) || (awaddr_reg == `RPM_A_STAT);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RPM_RESP_OKAY;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 8'h00;
         wlane_reg <= 1'b0;
         soft_reset_bit_start <= 1'b0;
      end
      else
      begin
         soft_reset_bit_start <= wr_aux1 & wdata_reg[`RPM_AUX1_SOFT_RESET_BIT];
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_reg <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata[7:0];
            wlane_reg <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RPM_RESP_OKAY : `RPM_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI read path
   reg [7:0] rd_val;
   reg rd_hit;
   always @*
   begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      case ({s_axi_araddr[11:2], 2'h0})
         `RPM_A_PWR:
         begin
            rd_val[`RPM_PWR_POF] = pof_reg;
            rd_val[`RPM_PWR_WLE] = wle_reg;
            rd_val[`RPM_PWR_PD] = pd_reg;
            rd_val[`RPM_PWR_IDL] = idl_reg;
         end
         `RPM_A_AUX: rd_val[2:0] = aux_reg;
         `RPM_A_AUX1: rd_val[`RPM_AUX1_WAKE_ENABLE_BIT] = wake_enable_bit_reg;
         `RPM_A_STAT:
         begin
            rd_val[`RPM_ST_IDLE] = mode_reg[1];
            rd_val[`RPM_ST_PD] = mode_reg[2];
            rd_val[`RPM_ST_WAKE] = mode_reg[3];
            rd_val[`RPM_ST_EMU] = emu_reg;
            rd_val[`RPM_ST_RST] = core_reset_reg;
            rd_val[`RPM_ST_OSC] = osc_enable_reg;
            rd_val[`RPM_ST_RAMBLK] = ram_block_reg;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RPM_RESP_OKAY;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_val};
         s_axi_rresp <= rd_hit ? `RPM_RESP_OKAY : `RPM_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Wake from power-down: enabled, level-sensitive line held low
   wire wake_low = (irq_en_zero & irq_level_zero & ~irq0_n_lvl)
      | (irq_en_one & irq_level_one & ~irq1_n_lvl);

   // Mode sequencing
   always @*
   begin
      mode_next = mode_reg;
      case (mode_reg)
         M_RUN:
            if (core_instr_done & pd_reg)
               mode_next = M_PD;
            else if (core_instr_done & idl_reg)
               mode_next = M_IDLE;
         M_IDLE:
            if (irq_pending | rst_lvl)
               mode_next = M_RUN;
         M_PD:
            if (wake_enable_bit_reg & wake_low)
               mode_next = M_WAKE;
         M_WAKE:
            if (!wake_low)
               mode_next = M_RUN;
         default: mode_next = M_RUN;
      endcase
      if (int_rst)
         mode_next = M_RUN;
   end

   // Mode and register bits; registers hold with no clock activity
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg <= M_RUN;
         pof_reg <= 1'b1;
         wle_reg <= 1'b0;
         pd_reg <= 1'b0;
         idl_reg <= 1'b0;
         aux_reg <= `RPM_AUX_RST;
         wake_enable_bit_reg <= 1'b0;
         ram_block_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         if (wr_pwr)
            pof_reg <= wdata_reg[`RPM_PWR_POF];
         if (power_on_detect)
            pof_reg <= 1'b1;
         if (int_rst)
         begin
            wle_reg <= 1'b0;
            pd_reg <= 1'b0;
            idl_reg <= 1'b0;
            aux_reg <= `RPM_AUX_RST;
            wake_enable_bit_reg <= 1'b0;
         end
         else
         begin
            if (wr_pwr)
            begin
               wle_reg <= wdata_reg[`RPM_PWR_WLE];
               pd_reg <= wdata_reg[`RPM_PWR_PD] & powerdown_allow_input;
               idl_reg <= wdata_reg[`RPM_PWR_IDL];
            end
            if (wdt_loaded)
               wle_reg <= 1'b0;
            if (wr_aux)
               aux_reg <= wdata_reg[2:0];
            if (wr_aux1)
               wake_enable_bit_reg <= wdata_reg[`RPM_AUX1_WAKE_ENABLE_BIT];
            if (mode_reg == M_IDLE && mode_next == M_RUN)
               idl_reg <= 1'b0;
            if (mode_reg == M_WAKE && mode_next == M_RUN)
               pd_reg <= 1'b0;
         end
         if (int_rst)
            ram_block_reg <= 1'b0;
         else if (mode_reg == M_IDLE && rst_lvl)
            ram_block_reg <= 1'b1;
      end
   end

   // Emulation entry sampled across reset release
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         emu_reg <= 1'b0;
         emu_cand_reg <= 1'b0;
         core_reset_reg <= 1'b1;
      end
      else
      begin
         core_reset_reg <= int_rst;
         if (core_reset_reg)
            emu_cand_reg <= ~ale_lvl & progstore_strobe_n_lvl;
         if (core_reset_reg & ~int_rst)
            emu_reg <= emu_cand_reg & ~ale_lvl;
      end
   end

   // Pin and core control outputs
   wire n_idle = mode_next == M_IDLE;
   wire n_pd = mode_next == M_PD;
   wire n_wake = mode_next == M_WAKE;
   wire hands_off = emu_reg | int_rst;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_pullup_reg <= 1'b0;
         ale_o_reg <= 1'b1;
         ale_oe_reg <= 1'b0;
         progstore_strobe_n_o_reg <= 1'b1;
         progstore_strobe_n_oe_reg <= 1'b0;
         port0_float_reg <= 1'b1;
         pins_weak_pull_reg <= 1'b1;
         pwm_force_high_reg <= 1'b1;
         wdt_load_allow_reg <= 1'b0;
         cpu_halt_reg <= 1'b1;
         periph_halt_reg <= 1'b0;
         osc_enable_reg <= 1'b1;
      end
      else
      begin
         rst_pullup_reg <= wdt_act;
         wdt_load_allow_reg <= wle_reg & ~wdt_loaded;
         cpu_halt_reg <= n_idle | n_pd | n_wake | int_rst;
         // Peripherals stay frozen until the wake-up exit completes
         periph_halt_reg <= n_pd | n_wake;
         osc_enable_reg <= ~n_pd | rst_lvl;
         pwm_force_high_reg <= n_idle | n_pd | n_wake | hands_off;
         port0_float_reg <= emu_reg | (ext_prog_mem & (n_idle | n_pd | n_wake));
         pins_weak_pull_reg <= hands_off;
         ale_oe_reg <= ~hands_off;
         progstore_strobe_n_oe_reg <= ~hands_off;
         if (n_idle)
         begin
            ale_o_reg <= 1'b1;
            progstore_strobe_n_o_reg <= 1'b1;
         end
         else if (n_pd | n_wake)
         begin
            ale_o_reg <= 1'b0;
            progstore_strobe_n_o_reg <= 1'b0;
         end
         else
         begin
            ale_o_reg <= aux_reg[`RPM_AUX_AO] ? (ext_mem_access & core_ale) : core_ale;
            progstore_strobe_n_o_reg <= core_progstore_strobe_n_n;
         end
      end
   end
endmodule

// ### bench/rpm_pins_model.sv
`timescale 1ns/1ns
module rpm_pins_model #(
   parameter RST_MIN = 32
) (
   // Clock
   input wire logic aclk,
   // Requests from the bench
   input wire logic rst_req,
   input wire logic irq0_req,
   input wire logic irq1_req,
   input wire logic emu_req,
   // Device side of the pins
   input wire logic rst_pullup_reg,
   input wire logic ale_o_reg,
   input wire logic ale_oe_reg,
   input wire logic progstore_strobe_n_o_reg,
   input wire logic progstore_strobe_n_oe_reg,
   output logic rst_pin,
   output logic ext_irq_zero_n,
   output logic ext_irq_one_n,
   output logic ale_i,
   output logic progstore_strobe_n_i
);
   logic drv_reg = 1'b0;
   integer hold_cnt = 0;
   // Stretch the reset request past the synchroniser plus two machine cycles
   always @(posedge aclk)
   begin
      if (rst_req)
         hold_cnt <= RST_MIN;
      else if (hold_cnt > 0)
         hold_cnt <= hold_cnt - 1;
      drv_reg <= rst_req || hold_cnt > 1;
   end
   // Watchdog pull-up shares the line
   assign rst_pin = drv_reg | rst_pullup_reg;
   // Pulled-up lines, low only while asked
   assign ext_irq_zero_n = !irq0_req;
   assign ext_irq_one_n = !irq1_req;
   // Emulator holds ALE low through reset release; the program-store strobe stays high
   assign ale_i = ale_oe_reg ? ale_o_reg : !emu_req;
   assign progstore_strobe_n_i = progstore_strobe_n_oe_reg ? progstore_strobe_n_o_reg : 1'b1;
endmodule

// ### bench/rpm_power_ctrl_sva.sv
`timescale 1ns/1ns
module rpm_power_ctrl_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Reset sources
   input wire logic rst_pin,
   input wire logic rst_pullup_reg,
   input wire logic core_reset_reg,
   input wire logic wdt_overflow,
   input wire logic wdt_enable,
   input wire logic wdt_loaded,
   input wire logic wdt_load_allow_reg,
   // Modes and pins
   input wire logic irq_pending,
   input wire logic cpu_halt_reg,
   input wire logic periph_halt_reg,
   input wire logic osc_enable_reg,
   input wire logic int_clk_reg,
   input wire logic ale_o_reg,
   input wire logic ale_oe_reg,
   input wire logic progstore_strobe_n_o_reg,
   input wire logic progstore_strobe_n_oe_reg,
   input wire logic port0_float_reg,
   input wire logic pins_weak_pull_reg,
   input wire logic pwm_force_high_reg
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] pull_cnt_reg;
   logic [7:0] pin_cnt_reg;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pull_cnt_reg <= 8'h00;
         pin_cnt_reg <= 8'h00;
      end
      else
      begin
         pull_cnt_reg <= rst_pullup_reg ? pull_cnt_reg + 8'h01 : 8'h00;
         pin_cnt_reg <= rst_pin ? pin_cnt_reg + 8'h01 : 8'h00;
      end
   end
   sequence idle_s;
      cpu_halt_reg && !periph_halt_reg && osc_enable_reg && !core_reset_reg && !pins_weak_pull_reg;
   endsequence
   sequence pd_s;
      !osc_enable_reg;
   endsequence
   sequence wdt_fire_s;
      wdt_overflow && wdt_enable && !rst_pullup_reg;
   endsequence
   wdt_pulse_len_a: assert property ($fell(rst_pullup_reg) |-> pull_cnt_reg == 8'h24)
      else $error("watchdog pulse length wrong");
   wdt_force_rst_a: assert property (wdt_fire_s |-> ##[1:2] (rst_pullup_reg && core_reset_reg))
      else $error("watchdog overflow gave no reset");
   pin_reset_a: assert property (pin_cnt_reg == 8'h20 |-> core_reset_reg)
      else $error("held reset pin gave no reset");
   idle_pins_a: assert property (idle_s |-> ale_o_reg && progstore_strobe_n_o_reg && pwm_force_high_reg)
      else $error("idle pin levels wrong");
   pd_pins_a: assert property (pd_s |-> !ale_o_reg && !progstore_strobe_n_o_reg && cpu_halt_reg && periph_halt_reg && pwm_force_high_reg)
      else $error("power-down pin levels wrong");
   clk_run_a: assert property (osc_enable_reg [*4] |-> $changed(int_clk_reg))
      else $error("internal clock not toggling");
   clk_stop_a: assert property (pd_s ##1 pd_s |-> $stable(int_clk_reg))
      else $error("internal clock runs in power-down");
   load_clear_a: assert property (wdt_loaded |=> !wdt_load_allow_reg)
      else $error("load enable not cleared");
   idle_exit_a: assert property (idle_s ##0 irq_pending |-> ##[1:2] !cpu_halt_reg)
      else $error("idle not left on interrupt");
   emu_pins_a: assert property (pins_weak_pull_reg && !core_reset_reg |-> port0_float_reg && !ale_oe_reg && !progstore_strobe_n_oe_reg && osc_enable_reg)
      else $error("emulation pin state wrong");
endmodule
bind rpm_power_ctrl rpm_power_ctrl_sva i_rpm_power_ctrl_sva (.*);

// ### bench/reset_and_power_mode_control_test.sv
`timescale 1ns/1ns
`include "rpm_consts.vh"
module reset_and_power_mode_control_test;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rst_pin, rst_pullup_reg, ext_irq_zero_n, ext_irq_one_n, port0_float_reg;
   logic ale_i, ale_o_reg, ale_oe_reg, progstore_strobe_n_i, progstore_strobe_n_o_reg;
   logic progstore_strobe_n_oe_reg, pins_weak_pull_reg, pwm_force_high_reg;
   logic wdt_overflow = 1'b0, wdt_enable = 1'b0, wdt_loaded = 1'b0, wdt_load_allow_reg;
   logic core_instr_done = 1'b0, irq_pending = 1'b0, irq_en_zero = 1'b1, irq_en_one = 1'b1;
   logic irq_level_zero = 1'b1, irq_level_one = 1'b1, powerdown_allow_input = 1'b0;
   logic core_ale = 1'b0, core_progstore_strobe_n_n = 1'b1, ext_prog_mem = 1'b0, ext_mem_access = 1'b0;
   logic power_on_detect = 1'b0, int_clk_reg, cpu_halt_reg, periph_halt_reg;
   logic osc_enable_reg, core_reset_reg, ram_block_reg;
   logic rst_req = 1'b0, irq0_req = 1'b0, irq1_req = 1'b0, emu_req = 1'b0;
   integer errors = 0, comparisons = 0, seed = 32'h588f, k;
   logic [7:0] d;
   rpm_power_ctrl i_rpm_power_ctrl (.*);
   rpm_pins_model i_rpm_pins_model (.*);
   initial
      forever #20 aclk = ~aclk;
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   function automatic logic [7:0] aux_exp(input logic [7:0] v);
      return v & 8'h07;
   endfunction
   task step(input integer n);
   begin
      repeat (n) @(posedge aclk);
   end
   endtask
   task axi_wr(input [11:0] a, input [7:0] v, input [1:0] er);
      logic aw, w, b;
   begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      b = 1'b0;
      while (!b)
      begin
         @(posedge aclk);
         if (!aw && !w && s_axi_bvalid)
         begin
            b = 1'b1;
            s_axi_bready <= 1'b0;
            chk(32'(s_axi_bresp), 32'(er), "bresp");
         end
         if (aw && s_axi_awready)
         begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready)
         begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
   end
   endtask
   task axi_rd(input [11:0] a, input [7:0] ev, input [1:0] er);
      logic ar, r;
   begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar = 1'b1;
      r = 1'b0;
      while (!r)
      begin
         @(posedge aclk);
         if (!ar && s_axi_rvalid)
         begin
            r = 1'b1;
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, {24'h0, ev}, "rdata");
            chk(32'(s_axi_rresp), 32'(er), "rresp");
         end
         if (ar && s_axi_arready)
         begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end
   end
   endtask
   task instr_done;
   begin
      core_instr_done <= 1'b1;
      step(1);
      core_instr_done <= 1'b0;
      step(2);
   end
   endtask
   task rst_lo;
   begin
      step(30);
      rst_req <= 1'b0;
      step(80);
   end
   endtask
   task end_of_test;
   begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors = errors + 1;
      end_of_test;
   end
   initial
   begin
      step(6);
      aresetn <= 1'b1;
      axi_rd(`RPM_A_PWR, 8'h20, `RPM_RESP_OKAY);
      axi_rd(`RPM_A_AUX, {5'h0, `RPM_AUX_RST}, `RPM_RESP_OKAY);
      axi_rd(`RPM_A_AUX1, 8'h00, `RPM_RESP_OKAY);
      axi_rd(12'h004, 8'h00, `RPM_RESP_SLVERR);
      axi_wr(12'h004, 8'hff, `RPM_RESP_SLVERR);
      for (k = 0; k < 4; k = k + 1)
      begin
         d = 8'($random(seed));
         core_progstore_strobe_n_n <= 1'($random(seed));
         axi_wr(`RPM_A_AUX, d, `RPM_RESP_OKAY);
         axi_rd(`RPM_A_AUX, aux_exp(d), `RPM_RESP_OKAY);
      end
      axi_wr(`RPM_A_PWR, 8'h10, `RPM_RESP_OKAY);
      axi_rd(`RPM_A_PWR, 8'h10, `RPM_RESP_OKAY);
      chk(wdt_load_allow_reg, 1'b1, "load enable");
      wdt_loaded <= 1'b1;
      step(1);
      wdt_loaded <= 1'b0;
      axi_rd(`RPM_A_PWR, 8'h00, `RPM_RESP_OKAY);
      power_on_detect <= 1'b1;
      step(1);
      power_on_detect <= 1'b0;
      axi_rd(`RPM_A_PWR, 8'h20, `RPM_RESP_OKAY);
      axi_wr(`RPM_A_PWR, 8'h00, `RPM_RESP_OKAY);
      $display("test registers finished");
      axi_wr(`RPM_A_AUX, 8'h01, `RPM_RESP_OKAY);
      core_ale <= 1'b1;
      step(4);
      chk(ale_o_reg, 1'b0, "ale suppressed");
      ext_mem_access <= 1'b1;
      step(4);
      chk(ale_o_reg, 1'b1, "ale external");
      ext_mem_access <= 1'b0;
      step(4);
      chk(ale_o_reg, 1'b0, "ale back off");
      axi_wr(`RPM_A_AUX, 8'h00, `RPM_RESP_OKAY);
      s_axi_wstrb <= 4'he;
      axi_wr(`RPM_A_AUX, 8'h07, `RPM_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axi_rd(`RPM_A_AUX, 8'h00, `RPM_RESP_OKAY);
      $display("test strobe off finished");
      axi_wr(`RPM_A_PWR, 8'h01, `RPM_RESP_OKAY);
      instr_done;
      chk({cpu_halt_reg, periph_halt_reg, ale_o_reg}, 3'b101, "idle");
      chk({progstore_strobe_n_o_reg, pwm_force_high_reg}, 2'b11, "idle pins");
      axi_rd(`RPM_A_STAT, 8'((1 << `RPM_ST_IDLE) | (1 << `RPM_ST_OSC)), `RPM_RESP_OKAY);
      irq_pending <= 1'b1;
      step(3);
      irq_pending <= 1'b0;
      chk(cpu_halt_reg, 1'b0, "idle exit");
      axi_rd(`RPM_A_PWR, 8'h00, `RPM_RESP_OKAY);
      axi_wr(`RPM_A_PWR, 8'h01, `RPM_RESP_OKAY);
      instr_done;
      rst_req <= 1'b1;
      step(10);
      chk({ram_block_reg, cpu_halt_reg}, 2'b10, "idle reset");
      rst_lo;
      chk(core_reset_reg, 1'b0, "reset over");
      $display("test idle finished");
      axi_wr(`RPM_A_PWR, 8'h02, `RPM_RESP_OKAY);
      axi_rd(`RPM_A_PWR, 8'h00, `RPM_RESP_OKAY);
      powerdown_allow_input <= 1'b1;
      ext_prog_mem <= 1'b1;
      axi_wr(`RPM_A_AUX, 8'h00, `RPM_RESP_OKAY);
      axi_wr(`RPM_A_PWR, 8'h02, `RPM_RESP_OKAY);
      instr_done;
      chk({osc_enable_reg, periph_halt_reg, port0_float_reg}, 3'b011, "pd");
      irq0_req <= 1'b1;
      step(12);
      chk(osc_enable_reg, 1'b0, "pd no wake");
      irq0_req <= 1'b0;
      rst_req <= 1'b1;
      step(10);
      chk(osc_enable_reg, 1'b1, "pd reset exit");
      rst_lo;
      ext_prog_mem <= 1'b0;
      axi_rd(`RPM_A_AUX, {5'h0, `RPM_AUX_RST}, `RPM_RESP_OKAY);
      for (k = 0; k < 2; k = k + 1)
      begin
         irq_en_zero <= (k == 0);
         irq_level_zero <= (k == 0);
         irq_en_one <= (k == 1);
         irq_level_one <= (k == 1);
         axi_wr(`RPM_A_AUX1, 8'h08, `RPM_RESP_OKAY);
         axi_wr(`RPM_A_PWR, 8'h02, `RPM_RESP_OKAY);
         instr_done;
         irq0_req <= (k == 0);
         irq1_req <= (k == 1);
         step(12);
         chk({osc_enable_reg, cpu_halt_reg}, 2'b11, "wake restart");
         irq0_req <= 1'b0;
         irq1_req <= 1'b0;
         step(12);
         chk({osc_enable_reg, cpu_halt_reg}, 2'b10, "wake done");
         axi_rd(`RPM_A_PWR, 8'h00, `RPM_RESP_OKAY);
         axi_rd(`RPM_A_AUX, {5'h0, `RPM_AUX_RST}, `RPM_RESP_OKAY);
      end
      $display("test power-down finished");
      for (k = 0; k < 2; k = k + 1)
      begin
         wdt_enable <= k[0];
         wdt_overflow <= 1'b1;
         step(1);
         wdt_overflow <= 1'b0;
         step(3);
         chk({rst_pullup_reg, core_reset_reg}, {k[0], k[0]}, "watchdog");
         step(60);
      end
      wdt_enable <= 1'b0;
      axi_wr(`RPM_A_AUX1, 8'h20, `RPM_RESP_OKAY);
      step(3);
      chk(core_reset_reg, 1'b1, "soft reset");
      step(40);
      axi_rd(`RPM_A_AUX1, 8'h00, `RPM_RESP_OKAY);
      $display("test resets finished");
      emu_req <= 1'b1;
      rst_req <= 1'b1;
      rst_lo;
      chk({pins_weak_pull_reg, port0_float_reg, ale_oe_reg}, 3'b110, "emulation");
      axi_rd(`RPM_A_STAT, 8'((1 << `RPM_ST_EMU) | (1 << `RPM_ST_OSC)), `RPM_RESP_OKAY);
      emu_req <= 1'b0;
      step(10);
      chk(pins_weak_pull_reg, 1'b1, "emulation held");
      rst_req <= 1'b1;
      rst_lo;
      chk(pins_weak_pull_reg, 1'b0, "emulation left");
      $display("test emulation finished");
      end_of_test;
   end
endmodule
